//--- hdl/cia_accept.sv
// interrupt acceptance unit: enable latches, pending nmi, vectoring sequencer
// How it works
// RL1 - reset clears enables, selects mode 0
// RL2 - reset drives control outputs inactive high
// RL3 - reset loads page and refresh with 00H
// RL4 - reset leaves other registers unchanged
// RL5 - non-maskable request ignores enable latches
// RL6 - reset, disable, maskable accept clear both
// RL7 - enable instruction sets both latches
// RL8 - enable defers acceptance one further instruction
// RL9 - nmi accept copies main into shadow
// RL10 - main stays clear until enable or return
// RL11 - page/refresh loads put shadow in parity
// RL12 - nmi return copies shadow to main
// RL13 - nmi falling edge sets pending flop
// RL14 - pending sampled at instruction last clock
// RL15 - maskable needs pin low, main set, no hold
// RL16 - nmi accept clears, pushes pc, jumps 66H
// RL17 - mode 0 executes peripheral-supplied instruction
// RL18 - mode 1 jumps to 0038H after push
// RL19 - mode 2 table pointer page:vector, low first
// RL20 - nmi wins when both acceptable
module cia_accept (
   input wire logic clock,
   input wire logic rst,
   input wire logic nmiReqN,
   input wire logic intReqN,
   input wire logic busHoldReqN,
   input wire cia_pkg::cia_instr_t instr,
   input wire logic [15:0] pcIn,
   input wire logic [15:0] spIn,
   input wire logic [7:0] busData,
   input wire logic busDone,
   output logic mainEnable,
   output logic shadowEnable,
   output logic [1:0] irqMode,
   output logic parityFlag,
   output logic parityLoad,
   output logic [7:0] pageReg,
   output logic [7:0] refreshReg,
   output cia_pkg::cia_bus_t bus_hold_request,
   output logic [15:0] pcLoad,
   output logic pcLoadValid,
   output logic [15:0] spOut,
   output logic spLoadValid,
   output logic busy,
   output logic opcodeInject,
   output logic [7:0] opcodeData,
   output logic haltClearN,
   output logic intAckN,
   output logic retiNotify
);
   typedef struct packed {
      logic mainEn;
      logic shadowEn;
      logic [1:0] mode;
      logic nmiPend;
      logic [1:0] eiDefer;
      logic parity;
      logic parityLd;
      logic [7:0] page;
      logic [7:0] refresh;
      cia_pkg::cia_state_t st;
      logic busy;
      logic isNmi;
      logic [15:0] target;
      logic [15:0] sp;
      logic [15:0] pc;
      logic [7:0] vecLo;
      cia_pkg::cia_bus_t bus;
      logic [15:0] pcLd;
      logic pcLdV;
      logic spLdV;
      logic inject;
      logic [7:0] injData;
      logic haltClrN;
      logic ackN;
      logic return_from_maskable;
   } cia_state_s_t;

   cia_state_s_t s_r;
   cia_state_s_t s_nxt;

   logic [2:0] pinSync;
   logic [2:0] pinFall;
   logic nmiTake;
   logic intTake;

   // request pins cross into the clock domain here
   cia_pin_sync #(
      .WIDTH(3)
   ) uSync (
      .clock(clock),
      .rst(rst),
      .pinIn({busHoldReqN, intReqN, nmiReqN}),
      .syncOut(pinSync),
      .fallPulse(pinFall)
   );

   // decisions only at an instruction boundary while the sequencer is idle
   always_comb begin
      // RL14 sample at last
      nmiTake = instr.lastClock && (s_r.st == cia_pkg::CIA_IDLE) &&
                (s_r.nmiPend || pinFall[0]);
      // RL15 maskable gate terms; RL8 deferral blocks one instruction
      // RL20 nmi takes priority
      intTake = instr.lastClock && (s_r.st == cia_pkg::CIA_IDLE) && !nmiTake &&
                !pinSync[1] && s_r.mainEn && pinSync[2] && s_r.eiDefer == 2'h0 &&
                !instr.enableIrq;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.pcLdV = 1'b0;
      s_nxt.spLdV = 1'b0;
      s_nxt.inject = 1'b0;
      s_nxt.parityLd = 1'b0;
      s_nxt.haltClrN = 1'b1;
      s_nxt.ackN = 1'b1;
      s_nxt.return_from_maskable = 1'b0;
      s_nxt.bus.busWrite = 1'b0;
      s_nxt.bus.busRead = 1'b0;
      s_nxt.bus.intAck = 1'b0;
      // RL13 edge sets pending
      if (pinFall[0]) begin
         s_nxt.nmiPend = 1'b1;
      end
      // deferral counts instruction ends; the enable pulse may come on any clock,
      // and one on the last clock has already used up its own instruction end
      if (instr.lastClock && s_r.eiDefer != 2'h0) begin
         s_nxt.eiDefer = s_r.eiDefer - 2'h1;
      end
      if (instr.enableIrq) begin
         s_nxt.eiDefer = instr.lastClock ? 2'h1 : 2'h2;
      end
      // RL7 enable sets both
      if (instr.enableIrq) begin
         s_nxt.mainEn = 1'b1;
         s_nxt.shadowEn = 1'b1;
      end
      // RL6 disable clears both
      if (instr.disableIrq) begin
         s_nxt.mainEn = 1'b0;
         s_nxt.shadowEn = 1'b0;
      end
      // RL12 shadow restores main
      if (instr.retNmi) begin
         s_nxt.mainEn = s_r.shadowEn;
         s_nxt.st = cia_pkg::CIA_POP;
         s_nxt.bus.busRead = 1'b1;
         s_nxt.bus.addr = spIn;
         s_nxt.sp = spIn;
      end
      if (instr.retIrq) begin
         s_nxt.return_from_maskable = 1'b1;
         s_nxt.st = cia_pkg::CIA_POP;
         s_nxt.bus.busRead = 1'b1;
         s_nxt.bus.addr = spIn;
         s_nxt.sp = spIn;
      end
      // RL11 shadow into parity
      if (instr.loadAccPage || instr.loadAccRefresh) begin
         s_nxt.parity = s_r.shadowEn;
         s_nxt.parityLd = 1'b1;
      end
      if (instr.setMode) begin
         s_nxt.mode = instr.newMode;
      end
      if (instr.writePage) begin
         s_nxt.page = instr.writeData;
      end
      if (instr.writeRefresh) begin
         s_nxt.refresh = instr.writeData;
      end
      // RL5 no latch gating
      if (nmiTake) begin
         // RL16 clear pending, main
         s_nxt.nmiPend = 1'b0;
         // RL9 main copied to shadow
         s_nxt.shadowEn = s_r.mainEn;
         // RL10 main held clear
         s_nxt.mainEn = 1'b0;
         s_nxt.isNmi = 1'b1;
         s_nxt.target = cia_pkg::NMI_VECTOR;
         s_nxt.haltClrN = 1'b0;
         s_nxt.pc = pcIn;
         s_nxt.sp = spIn - 16'h0001;
         s_nxt.bus.busWrite = 1'b1;
         s_nxt.bus.addr = spIn - 16'h0001;
         s_nxt.bus.wdata = pcIn[15:8];
         s_nxt.st = cia_pkg::CIA_PUSHH;
      end else if (intTake) begin
         // RL6 maskable accept clears
         s_nxt.mainEn = 1'b0;
         s_nxt.shadowEn = 1'b0;
         s_nxt.isNmi = 1'b0;
         s_nxt.haltClrN = 1'b0;
         s_nxt.ackN = 1'b0;
         s_nxt.bus.intAck = 1'b1;
         s_nxt.pc = pcIn;
         s_nxt.sp = spIn;
         s_nxt.target = cia_pkg::MODE1_VECTOR;
         s_nxt.st = cia_pkg::CIA_VECLO;
      end
      case (s_r.st)
         cia_pkg::CIA_IDLE: begin
         end
         cia_pkg::CIA_VECLO: begin
            // vector byte from the acknowledging peripheral
            s_nxt.bus.intAck = 1'b1;
            s_nxt.ackN = 1'b0;
            if (busDone) begin
               s_nxt.bus.intAck = 1'b0;
               s_nxt.ackN = 1'b1;
               if (s_r.mode == cia_pkg::CIA_MODE0) begin
                  // RL17 peripheral opcode executed
                  s_nxt.inject = 1'b1;
                  s_nxt.injData = busData;
                  s_nxt.st = cia_pkg::CIA_IDLE;
               end else begin
                  // RL19 pointer lsb forced zero
                  s_nxt.vecLo = {busData[7:1], 1'b0};
                  s_nxt.sp = s_r.sp - 16'h0001;
                  s_nxt.bus.busWrite = 1'b1;
                  s_nxt.bus.addr = s_r.sp - 16'h0001;
                  s_nxt.bus.wdata = s_r.pc[15:8];
                  s_nxt.st = cia_pkg::CIA_PUSHH;
               end
            end
         end
         cia_pkg::CIA_PUSHH: begin
            s_nxt.bus.busWrite = 1'b1;
            if (busDone) begin
               s_nxt.sp = s_r.sp - 16'h0001;
               s_nxt.bus.addr = s_r.sp - 16'h0001;
               s_nxt.bus.wdata = s_r.pc[7:0];
               s_nxt.st = cia_pkg::CIA_PUSHL;
            end
         end
         cia_pkg::CIA_PUSHL: begin
            s_nxt.bus.busWrite = 1'b1;
            if (busDone) begin
               s_nxt.bus.busWrite = 1'b0;
               s_nxt.spLdV = 1'b1;
               if (!s_r.isNmi && s_r.mode == cia_pkg::CIA_MODE2) begin
                  // RL19 table read low byte first
                  s_nxt.bus.busRead = 1'b1;
                  s_nxt.bus.addr = {s_r.page, s_r.vecLo};
                  s_nxt.st = cia_pkg::CIA_VECHI;
               end else begin
                  // RL18 fixed mode 1 vector; RL16 nmi vector
                  s_nxt.pcLd = s_r.target;
                  s_nxt.pcLdV = 1'b1;
                  s_nxt.st = cia_pkg::CIA_IDLE;
               end
            end
         end
         cia_pkg::CIA_VECHI: begin
            s_nxt.bus.busRead = 1'b1;
            if (busDone) begin
               if (s_r.bus.addr[0] == 1'b0) begin
                  s_nxt.target[7:0] = busData;
                  s_nxt.bus.addr = s_r.bus.addr + 16'h0001;
               end else begin
                  s_nxt.bus.busRead = 1'b0;
                  s_nxt.pcLd = {busData, s_r.target[7:0]};
                  s_nxt.pcLdV = 1'b1;
                  s_nxt.st = cia_pkg::CIA_IDLE;
               end
            end
         end
         cia_pkg::CIA_POP: begin
            // RL12 pc from stack
            s_nxt.bus.busRead = 1'b1;
            if (busDone) begin
               if (s_r.bus.addr == s_r.sp) begin
                  s_nxt.target[7:0] = busData;
                  s_nxt.bus.addr = s_r.sp + 16'h0001;
               end else begin
                  s_nxt.bus.busRead = 1'b0;
                  s_nxt.pcLd = {busData, s_r.target[7:0]};
                  s_nxt.pcLdV = 1'b1;
                  s_nxt.sp = s_r.sp + 16'h0002;
                  s_nxt.spLdV = 1'b1;
                  s_nxt.st = cia_pkg::CIA_IDLE;
               end
            end
         end
         default: begin
            s_nxt.st = cia_pkg::CIA_IDLE;
         end
      endcase
      // busy kept as its own flop so the port needs no decode
      s_nxt.busy = (s_nxt.st != cia_pkg::CIA_IDLE);
   end

   // reset loads interrupt state, page, refresh, control outputs and the scratch pc/sp copies;
   // every field here is reset, while the core's own registers stay untouched
   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= s_nxt;
         // RL1 enables off, mode 0
         s_r.mainEn <= 1'b0;
         s_r.shadowEn <= 1'b0;
         s_r.mode <= cia_pkg::CIA_MODE0;
         s_r.nmiPend <= 1'b0;
         s_r.eiDefer <= 2'h0;
         s_r.parity <= 1'b0;
         s_r.parityLd <= 1'b0;
         // RL3 page/refresh zero
         s_r.page <= cia_pkg::PAGE_RESET;
         s_r.refresh <= cia_pkg::REFRESH_RESET;
         s_r.st <= cia_pkg::CIA_IDLE;
         s_r.busy <= 1'b0;
         s_r.isNmi <= 1'b0;
         s_r.target <= cia_pkg::PC_RESET;
         s_r.sp <= cia_pkg::SP_RESET;
         s_r.pc <= cia_pkg::PC_RESET;
         s_r.vecLo <= 8'h00;
         s_r.bus <= '0;
         s_r.pcLd <= cia_pkg::PC_RESET;
         s_r.pcLdV <= 1'b0;
         s_r.spLdV <= 1'b0;
         s_r.inject <= 1'b0;
         s_r.injData <= 8'h00;
         // RL2 controls inactive high
         s_r.haltClrN <= 1'b1;
         s_r.ackN <= 1'b1;
         s_r.return_from_maskable <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // RL4 nothing else reset
   assign mainEnable = s_r.mainEn;
   assign shadowEnable = s_r.shadowEn;
   assign irqMode = s_r.mode;
   assign parityFlag = s_r.parity;
   assign parityLoad = s_r.parityLd;
   assign pageReg = s_r.page;
   assign refreshReg = s_r.refresh;
   assign bus_hold_request = s_r.bus;
   assign pcLoad = s_r.pcLd;
   assign pcLoadValid = s_r.pcLdV;
   assign spOut = s_r.sp;
   assign spLoadValid = s_r.spLdV;
   assign busy = s_r.busy;
   assign opcodeInject = s_r.inject;
   assign opcodeData = s_r.injData;
   assign haltClearN = s_r.haltClrN;
   assign intAckN = s_r.ackN;
   assign retiNotify = s_r.return_from_maskable;
endmodule

//--- hdl/cia_pkg.sv
// package: constants, modes, and carrier structs for the interrupt-acceptance block
package cia_pkg;
   localparam logic [15:0] NMI_VECTOR = 16'h0066;
   localparam logic [15:0] MODE1_VECTOR = 16'h0038;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] REFRESH_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;

   typedef enum logic [1:0] {
      CIA_MODE0 = 2'h0,
      CIA_MODE1 = 2'h1,
      CIA_MODE2 = 2'h2
   } cia_mode_t;

   // acceptance sequencer states, one-hot
   typedef enum logic [5:0] {
      CIA_IDLE = 6'h01,
      CIA_PUSHH = 6'h02,
      CIA_PUSHL = 6'h04,
      CIA_VECLO = 6'h08,
      CIA_VECHI = 6'h10,
      CIA_POP = 6'h20
   } cia_state_t;

   // instruction-side events from the sequencer, one-cycle pulses
   typedef struct packed {
      logic enableIrq;
      logic disableIrq;
      logic retNmi;
      logic retIrq;
      logic loadAccPage;
      logic loadAccRefresh;
      logic setMode;
      logic [1:0] newMode;
      logic writePage;
      logic writeRefresh;
      logic [7:0] writeData;
      logic lastClock;
   } cia_instr_t;

   // memory/bus request toward the bus unit
   typedef struct packed {
      logic busWrite;
      logic busRead;
      logic intAck;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cia_bus_t;
endpackage

//--- hdl/cia_pin_sync.sv
// two-flop synchroniser with falling-edge detect for the request pins
module cia_pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut,
   output logic [WIDTH-1:0] fallPulse
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } cia_sync_t;

   cia_sync_t state_r;
   cia_sync_t state_nxt;

   // pins idle high; the first stage feeds only the second
   always_comb begin
      state_nxt = state_r;
      state_nxt.meta = pinIn;
      state_nxt.sync = state_r.meta;
      state_nxt.prev = state_r.sync;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= '{meta: '1, sync: '1, prev: '1};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign syncOut = state_r.sync;

   // per-bit falling edge on the synchronised level
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : gEdge
         assign fallPulse[gi] = state_r.prev[gi] & ~state_r.sync[gi];
      end
   endgenerate
endmodule

//--- dv/cia_accept_assertions.sv
// checker: port timing relations of the interrupt acceptance unit
module cia_accept_assertions (
   input wire logic clock,
   input wire logic rst,
   input wire cia_pkg::cia_instr_t instr,
   input wire logic [15:0] pcIn,
   input wire logic [15:0] spIn,
   input wire logic mainEnable,
   input wire logic shadowEnable,
   input wire logic [1:0] irqMode,
   input wire logic parityFlag,
   input wire logic parityLoad,
   input wire logic [7:0] pageReg,
   input wire logic [7:0] refreshReg,
   input wire cia_pkg::cia_bus_t bus_hold_request,
   input wire logic [15:0] pcLoad,
   input wire logic pcLoadValid,
   input wire logic haltClearN,
   input wire logic intAckN
);
   default clocking cb @(posedge clock);
   endclocking
   // nmi acceptance: halt release together with a push, no acknowledge cycle first
   sequence s_nmiGo;
      $fell(haltClearN) && bus_hold_request.busWrite;
   endsequence
   property p_rstEna;
      rst |=> !mainEnable && !shadowEnable && irqMode == 2'h0;
   endproperty
   a_rstEna: assert property (p_rstEna)
      else $error("enables or mode not cleared by reset");
   property p_rstRegs;
      rst |=> pageReg == 8'h00 && refreshReg == 8'h00;
   endproperty
   a_rstRegs: assert property (p_rstRegs)
      else $error("page or refresh not zero after reset");
   property p_rstCtl;
      rst |=> haltClearN && intAckN && !bus_hold_request.busWrite && !bus_hold_request.busRead;
   endproperty
   a_rstCtl: assert property (p_rstCtl)
      else $error("control outputs active during reset");
   property p_ena;
      disable iff (rst) instr.enableIrq && !instr.disableIrq |=> mainEnable && shadowEnable;
   endproperty
   a_ena: assert property (p_ena)
      else $error("enable did not set both latches");
   property p_dis;
      disable iff (rst) instr.disableIrq |=> !mainEnable && !shadowEnable;
   endproperty
   a_dis: assert property (p_dis)
      else $error("disable did not clear both latches");
   property p_par;
      disable iff (rst) instr.loadAccPage || instr.loadAccRefresh
         |=> parityLoad && parityFlag == $past(shadowEnable);
   endproperty
   a_par: assert property (p_par)
      else $error("parity does not carry shadow latch");
   property p_ret;
      disable iff (rst) instr.retNmi && shadowEnable |-> ##[1:60] mainEnable;
   endproperty
   a_ret: assert property (p_ret)
      else $error("main latch not restored by return");
   property p_nmiEn;
      disable iff (rst) s_nmiGo |-> !mainEnable && shadowEnable == $past(mainEnable);
   endproperty
   a_nmiEn: assert property (p_nmiEn)
      else $error("latches wrong at nmi acceptance");
   property p_push;
      disable iff (rst) s_nmiGo
         |-> bus_hold_request.addr == $past(spIn) - 16'h0001 && bus_hold_request.wdata == $past(pcIn[15:8]);
   endproperty
   a_push: assert property (p_push)
      else $error("first push not pc high at sp-1");
   property p_vec;
      disable iff (rst) s_nmiGo |-> ##[2:200] pcLoadValid && pcLoad == cia_pkg::NMI_VECTOR;
   endproperty
   a_vec: assert property (p_vec)
      else $error("nmi did not reach its vector");
   c_nmi: cover property (s_nmiGo);
   c_par: cover property (parityLoad && parityFlag);
   c_ack: cover property (!intAckN);
endmodule
bind cia_accept cia_accept_assertions u_chk (.*);

//--- dv/cia_periph_model.sv
// peripheral and memory model facing the acceptance unit
module cia_periph_model (
   input wire logic clock,
   input wire logic nmiAssert,
   input wire logic intAssert,
   input wire logic [7:0] vec,
   input wire logic [1:0] lat,
   input wire cia_pkg::cia_bus_t bus_hold_request,
   output logic nmiReqN,
   output logic intReqN,
   output logic [7:0] busData,
   output logic busDone
);
   logic [7:0] mem [256];
   logic [1:0] cnt = 2'h0;
   assign nmiReqN = !nmiAssert;
   assign intReqN = !intAssert;
   initial begin
      busDone = 1'b0;
      busData = 8'h00;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end
   // answer each op after lat waits; data toggles once its cycle is over
   always @(posedge clock) begin
      busDone <= 1'b0;
      busData <= ~busData;
      if ((bus_hold_request.busWrite || bus_hold_request.busRead || bus_hold_request.intAck) && !busDone) begin
         if (cnt == lat) begin
            busDone <= 1'b1;
            cnt <= 2'h0;
            if (bus_hold_request.busWrite) begin
               mem[bus_hold_request.addr[7:0]] <= bus_hold_request.wdata;
            end
            // peripheral puts its byte on acknowledge
            if (bus_hold_request.intAck) begin
               busData <= vec;
            end else if (bus_hold_request.busRead) begin
               busData <= mem[bus_hold_request.addr[7:0]];
            end
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule

//--- dv/tb.sv
// testbench: instruction-level sequences against the acceptance unit
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int K_NOP = 0;
   localparam int K_ENA = 1;
   localparam int K_MOD = 2;
   localparam int K_PAG = 3;
   localparam int K_LDP = 4;
   localparam int K_RNM = 5;
   localparam int K_DIS = 6;
   localparam int K_LDR = 7;
   localparam int K_RTI = 8;
   logic clock, rst, nmiReqN, intReqN, busHoldReqN, busDone, pcLoadValid, busy;
   logic mainEnable, shadowEnable, parityFlag, opcodeInject, haltClearN, intAckN, retiNotify;
   logic retiSeen = 1'b0;
   logic nmiA, intA;
   logic [15:0] pcIn, spIn, pcLoad, spOut;
   logic [7:0] busData, opcodeData, pageReg, refreshReg, vec;
   logic [1:0] irqMode, lat;
   cia_pkg::cia_instr_t instr;
   cia_pkg::cia_bus_t bus_hold_request;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   cia_accept dut (.*, .spLoadValid(), .parityLoad());
   cia_periph_model peer (.clock(clock), .nmiAssert(nmiA), .intAssert(intA), .vec(vec),
      .lat(lat), .bus_hold_request(bus_hold_request), .nmiReqN(nmiReqN), .intReqN(intReqN),
      .busData(busData), .busDone(busDone));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // the return notice is a one-cycle pulse, so latch it where it has settled
   always @(negedge clock) begin
      if (retiNotify === 1'b1) retiSeen <= 1'b1;
   end
   // a hang ends the run as a failure
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   // one instruction: event cycle, then its last clock
   task op(input int k, input logic [7:0] d = 8'h00);
      cia_pkg::cia_instr_t v;
      v = '0;
      v.enableIrq = (k == K_ENA);
      v.disableIrq = (k == K_DIS);
      v.setMode = (k == K_MOD);
      v.newMode = d[1:0];
      v.writePage = (k == K_PAG);
      v.writeData = d;
      v.loadAccPage = (k == K_LDP);
      v.retNmi = (k == K_RNM);
      v.loadAccRefresh = (k == K_LDR);
      v.retIrq = (k == K_RTI);
      @(negedge clock);
      instr = v;
      v = '0;
      v.lastClock = 1'b1;
      @(negedge clock);
      instr = v;
      @(negedge clock);
      instr = '0;
   endtask
   // wait for new pc or injected opcode, compare, then let the sequencer drain
   task wt(input logic sel, input logic [15:0] e);
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge clock);
         if ((sel ? opcodeInject : pcLoadValid) === 1'b1) break;
      end
      chk("vector", sel ? {8'h00, opcodeData} : pcLoad, e);
      for (i = 0; i < 50 && busy !== 1'b0; i++) begin
         @(negedge clock);
      end
   endtask
   task finish_test;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      nmiA = 1'b0;
      intA = 1'b0;
      busHoldReqN = 1'b1;
      instr = '0;
      pcIn = 16'h1111;
      spIn = 16'h0080;
      vec = 8'hD7;
      lat = 2'h0;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      chk("enables", {12'h000, mainEnable, shadowEnable, irqMode}, 16'h0000);
      chk("regs", {pageReg, refreshReg}, 16'h0000);
      chk("ctl", {13'h0000, haltClearN, intAckN, busy}, 16'h0006);
      op(K_ENA);
      chk("enables", {14'h0000, mainEnable, shadowEnable}, 16'h0003);
      op(K_DIS);
      chk("enables", {14'h0000, mainEnable, shadowEnable}, 16'h0000);
      op(K_LDR);
      chk("parity", {15'h0000, parityFlag}, 16'h0000);
      intA = 1'b1;
      op(K_ENA);
      op(K_NOP);
      chk("busy", {15'h0000, busy}, 16'h0000);
      op(K_NOP);
      wt(1'b1, 16'h00D7);
      chk("enables", {14'h0000, mainEnable, shadowEnable}, 16'h0000);
      op(K_MOD, 8'h01);
      busHoldReqN = 1'b0;
      op(K_ENA);
      op(K_NOP);
      op(K_NOP);
      chk("busy", {15'h0000, busy}, 16'h0000);
      busHoldReqN = 1'b1;
      repeat (2) @(negedge clock);
      op(K_NOP);
      wt(1'b0, 16'h0038);
      lat = 2'h3;
      vec = 8'h35;
      op(K_PAG, 8'h12);
      op(K_MOD, 8'h02);
      op(K_ENA);
      op(K_NOP);
      op(K_NOP);
      wt(1'b0, 16'h6F6E);
      pcIn = 16'h4321;
      op(K_ENA);
      op(K_NOP);
      nmiA = 1'b1;
      repeat (4) @(negedge clock);
      op(K_NOP);
      wt(1'b0, cia_pkg::NMI_VECTOR);
      chk("enables", {14'h0000, mainEnable, shadowEnable}, 16'h0001);
      chk("sp", spOut, 16'h007E);
      nmiA = 1'b0;
      op(K_NOP);
      chk("busy", {15'h0000, busy}, 16'h0000);
      op(K_LDP);
      chk("parity", {15'h0000, parityFlag}, 16'h0001);
      spIn = 16'h007E;
      op(K_RNM);
      wt(1'b0, 16'h4321);
      chk("enables", {14'h0000, mainEnable, shadowEnable}, 16'h0003);
      chk("sp", spOut, 16'h0080);
      chk("return_from_maskable", {15'h0000, retiSeen}, 16'h0000);
      op(K_RTI);
      wt(1'b0, 16'h4321);
      chk("return_from_maskable", {15'h0000, retiSeen}, 16'h0001);
      chk("enables", {14'h0000, mainEnable, shadowEnable}, 16'h0003);
      finish_test();
   end
endmodule
